// ==== btzc_zone_ctrl.v ====
// Purpose: Battery temperature zone supervision with Wishbone registers.
// Assumes: Comparator flags synchronous to clk_i, analog done elsewhere.
// Notes:   Single-cycle ack on every access; unmapped reads return zero.
//          Charger timers and the charger state machine live outside;
//          this block only says when to pause and which settings apply.
//
// Local design decisions: the register addresses and the Wishbone interface to the registers.
module btzc_zone_ctrl
(
  // Clock and reset.
  input  wire        clk_i,
  input  wire        rst_i,
  // Wishbone classic slave.
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [7:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output wire        ack_o,
  // Comparator flags, high when past the matching threshold.
  input  wire        hot_cmp_i,
  input  wire        warm_cmp_i,
  input  wire        cool_cmp_i,
  input  wire        cold_cmp_i,
  // Charger side.
  input  wire        charger_input_valid_i,
  input  wire        other_fault_i,
  // Outputs towards the analog and the charger state machine.
  output reg  [7:0]  threshold_sel_o,
  output reg         thermistor_bias_en_o,
  output reg  [5:0]  active_voltage_o,
  output reg  [5:0]  active_current_o,
  output reg         modified_state_o,
  output reg         temp_fault_o,
  output reg         charge_pause_o,
  output reg         timer_pause_o,
  output reg         fault_o,
  output reg  [3:0]  monitor_mux_sel_o,
  output wire        irq_o
);
`include "btzc_defines.vh"

  // Steps of charge voltage making up the system voltage margin; the
  // division runs at full width and is then cut to the code width.
  localparam integer MARGIN_RAW   = `BTZC_MARGIN_MV / `BTZC_STEP_MV;
  localparam [5:0]   MARGIN_STEPS = MARGIN_RAW[5:0];

  // Charger activity states mirrored around the temperature fault.
  localparam [1:0] ST_RUN   = 2'h0;
  localparam [1:0] ST_TEMPF = 2'h1;
  localparam [1:0] ST_OTHER = 2'h2;

  // Registers written by software, then internal state and bus flops.
  reg        thermistor_enable_q;
  reg  [3:0] mux_sel_q;
  reg  [7:0] thr_q;
  reg  [5:0] charge_voltage_setting_q;
  reg  [5:0] charge_current_q;
  reg  [5:0] modified_charge_voltage_q;
  reg  [5:0] modified_charge_current_q;
  reg  [5:0] sysv_q;
  reg  [1:0] irq_stat_q;
  reg  [1:0] irq_mask_q;
  reg  [2:0] zone_prev_q;
  reg  [1:0] state_q;
  reg  [1:0] state_d;
  reg  [1:0] saved_state_q;
  reg        ack_q;

  wire [2:0] temp_zone_status;
  wire       wr_acc;
  wire       rd_acc;
  wire       sysv_short;
  wire [5:0] cv_limit;
  wire       zone_extreme;
  wire       zone_mod;
  wire       temp_change_irq;
  wire       sysv_config_error_irq;

  // Byte-lane merge for the low byte, the only lane the registers use.
  // A write with sel_i[0] low leaves every register as it was.
  function [7:0] lane0;
    input [7:0] old;
    input [3:0] sel;
    input [7:0] dat;
    begin
      lane0 = sel[0] ? dat : old;
    end
  endfunction

  // Highest charge-voltage code keeping the system margin.
  // It saturates at zero rather than wrapping round to a high code.
  function [5:0] cv_ceiling;
    input [5:0] sysv;
    begin
      cv_ceiling = (sysv > MARGIN_STEPS) ? (sysv - MARGIN_STEPS) : 6'h00;
    end
  endfunction

  // Classic Wishbone: one ack per strobe, dropped the cycle after it.
  assign wr_acc = cyc_i & stb_i & we_i & ~ack_q;
  assign rd_acc = cyc_i & stb_i & ~we_i & ~ack_q;
  assign ack_o  = ack_q;

  // Ack is a registered pulse: raised one cycle after the strobe is
  // taken and dropped the next, so a master that keeps stb high across
  // the ack edge is never answered twice.
  always @(posedge clk_i)
  begin
    if (rst_i)
      ack_q <= 1'b0;
    else
      ack_q <= cyc_i & stb_i & ~ack_q;
  end

  // The classifier only sees comparator flags and the enable, never the
  // multiplexer selection, so external conversions cannot disturb it.
  btzc_zone_classify u_classify
  (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .enable_i (thermistor_enable_q),
    .hot_i    (hot_cmp_i),
    .warm_i   (warm_cmp_i),
    .cool_i   (cool_cmp_i),
    .cold_i   (cold_cmp_i),
    .zone_o   (temp_zone_status)
  );

  // The margin check is continuous, not tied to writes, so lowering the
  // system voltage later also pulls the charge voltage down. Both codes
  // share one step size; a system code at or below the margin clamps the
  // charge voltage to its lowest code.
  assign cv_limit   = cv_ceiling(sysv_q);
  assign sysv_short = charge_voltage_setting_q > cv_limit;

  // Configuration registers. Writes take effect at the ack edge; the
  // charge-voltage clamp follows any later write that breaks the margin.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      thermistor_enable_q       <= 1'b0;
      mux_sel_q                 <= 4'h0;
      thr_q                     <= `BTZC_THR_RST;
      charge_voltage_setting_q  <= `BTZC_CV_RST;
      charge_current_q          <= 6'h00;
      modified_charge_voltage_q <= 6'h00;
      modified_charge_current_q <= 6'h00;
      sysv_q                    <= `BTZC_SYSV_RST;
      irq_mask_q                <= 2'h0;
    end
    else
    begin
      if (wr_acc && adr_i == `BTZC_CTRL_OFS && sel_i[0])
      begin
        thermistor_enable_q <= dat_i[`BTZC_CTRL_EN_BIT];
        mux_sel_q           <= dat_i[`BTZC_CTRL_MUX_LSB +: 4];
      end
      if (wr_acc && adr_i == `BTZC_THR_OFS)
        thr_q <= lane0(thr_q, sel_i, dat_i[7:0]);
      if (wr_acc && adr_i == `BTZC_CHGC_OFS && sel_i[0])
        charge_current_q <= dat_i[5:0];
      if (wr_acc && adr_i == `BTZC_MODV_OFS && sel_i[0])
        modified_charge_voltage_q <= dat_i[5:0];
      if (wr_acc && adr_i == `BTZC_MODC_OFS && sel_i[0])
        modified_charge_current_q <= dat_i[5:0];
      if (wr_acc && adr_i == `BTZC_SYSV_OFS && sel_i[0])
        sysv_q <= dat_i[5:0];
      if (wr_acc && adr_i == `BTZC_MASK_OFS && sel_i[0])
        irq_mask_q <= dat_i[1:0];
      if (wr_acc && adr_i == `BTZC_CHGV_OFS && sel_i[0])
        charge_voltage_setting_q <= dat_i[5:0];
      else if (sysv_short)
        charge_voltage_setting_q <= cv_limit;
    end
  end

  // Zone edges and clamp events set sticky flags; a set in the same
  // cycle as a write-one-to-clear wins so no event is lost.
  assign temp_change_irq       = temp_zone_status != zone_prev_q;
  assign sysv_config_error_irq = sysv_short;

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_stat_q  <= 2'h0;
      zone_prev_q <= `BTZC_ZONE_OFF;
    end
    else
    begin
      zone_prev_q <= temp_zone_status;
      irq_stat_q[`BTZC_IRQ_TEMP_BIT] <= temp_change_irq |
        (irq_stat_q[`BTZC_IRQ_TEMP_BIT] &
         ~(wr_acc && adr_i == `BTZC_IRQ_OFS && sel_i[0] &&
           dat_i[`BTZC_IRQ_TEMP_BIT]));
      irq_stat_q[`BTZC_IRQ_SYSV_BIT] <= sysv_config_error_irq |
        (irq_stat_q[`BTZC_IRQ_SYSV_BIT] &
         ~(wr_acc && adr_i == `BTZC_IRQ_OFS && sel_i[0] &&
           dat_i[`BTZC_IRQ_SYSV_BIT]));
    end
  end

  // Level interrupt straight from flops; it stays high until every
  // unmasked sticky bit is cleared, so software cannot miss an event.
  assign irq_o = |(irq_stat_q & irq_mask_q);

  // Zone decode; a disabled thermistor reads as off and so is neither.
  assign zone_extreme = (temp_zone_status == `BTZC_ZONE_HOT) ||
                        (temp_zone_status == `BTZC_ZONE_COLD);
  assign zone_mod     = (temp_zone_status == `BTZC_ZONE_WARM) ||
                        (temp_zone_status == `BTZC_ZONE_COOL);

  // Temperature fault overrides any other fault and remembers what the
  // charger was doing, so leaving it restores that state untouched.
  always @*
  begin
    state_d = state_q;
    case (state_q)
      ST_RUN:
        if (zone_extreme)
          state_d = ST_TEMPF;
        else if (other_fault_i)
          state_d = ST_OTHER;
      ST_OTHER:
        if (zone_extreme)
          state_d = ST_TEMPF;
        else if (!other_fault_i)
          state_d = ST_RUN;
      ST_TEMPF:
        if (!zone_extreme)
          state_d = saved_state_q;
      default:
        state_d = ST_RUN;
    endcase
  end

  // State register. The saved state is taken only on the entry edge, so
  // a fault that lasts many cycles cannot overwrite it with itself.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q       <= ST_RUN;
      saved_state_q <= ST_RUN;
    end
    else
    begin
      state_q <= state_d;
      if (state_q != ST_TEMPF && state_d == ST_TEMPF)
        saved_state_q <= state_q;
    end
  end

  // Charge parameter selection and charger-facing status, registered.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      active_voltage_o     <= `BTZC_CV_RST;
      active_current_o     <= 6'h00;
      modified_state_o     <= 1'b0;
      temp_fault_o         <= 1'b0;
      charge_pause_o       <= 1'b0;
      timer_pause_o        <= 1'b0;
      fault_o              <= 1'b0;
      thermistor_bias_en_o <= 1'b0;
      threshold_sel_o      <= `BTZC_THR_RST;
      monitor_mux_sel_o    <= 4'h0;
    end
    else
    begin
      modified_state_o <= zone_mod;
      if (zone_mod)
      begin
        active_voltage_o <= modified_charge_voltage_q;
        active_current_o <= modified_charge_current_q;
      end
      else
      begin
        active_voltage_o <= charge_voltage_setting_q;
        active_current_o <= charge_current_q;
      end
      temp_fault_o   <= state_d == ST_TEMPF;
      charge_pause_o <= state_d != ST_RUN;
      timer_pause_o  <= state_d == ST_TEMPF;
      fault_o        <= state_d == ST_OTHER;
      // Bias follows either need and ignores the charger state, so an
      // external conversion sees a live thermistor even during a fault.
      thermistor_bias_en_o <=
        (charger_input_valid_i & thermistor_enable_q) |
        (mux_sel_q == `BTZC_MUX_THM) |
        (mux_sel_q == `BTZC_MUX_BIAS);
      threshold_sel_o   <= thr_q;
      monitor_mux_sel_o <= mux_sel_q;
    end
  end

  // Read data is registered and valid with ack.
  always @(posedge clk_i)
  begin
    if (rst_i)
      dat_o <= 32'h00000000;
    else if (rd_acc)
    begin
      case (adr_i)
        `BTZC_CTRL_OFS: dat_o <= {24'h000000, mux_sel_q, 3'h0,
                                  thermistor_enable_q};
        `BTZC_THR_OFS:  dat_o <= {24'h000000, thr_q};
        `BTZC_CHGV_OFS: dat_o <= {26'h0000000, charge_voltage_setting_q};
        `BTZC_CHGC_OFS: dat_o <= {26'h0000000, charge_current_q};
        `BTZC_MODV_OFS: dat_o <= {26'h0000000, modified_charge_voltage_q};
        `BTZC_MODC_OFS: dat_o <= {26'h0000000, modified_charge_current_q};
        `BTZC_SYSV_OFS: dat_o <= {26'h0000000, sysv_q};
        `BTZC_STAT_OFS: dat_o <= {29'h00000000, temp_zone_status};
        `BTZC_IRQ_OFS:  dat_o <= {30'h00000000, irq_stat_q};
        `BTZC_MASK_OFS: dat_o <= {30'h00000000, irq_mask_q};
        `BTZC_OUT_OFS:  dat_o <= {27'h0000000, timer_pause_o, temp_fault_o,
                                  modified_state_o, charge_pause_o,
                                  thermistor_bias_en_o};
        default:        dat_o <= 32'h00000000;
      endcase
    end
  end

endmodule // btzc_zone_ctrl

// ==== btzc_defines.vh ====
// Purpose: Offsets, field positions, reset values and codes for btzc.
// Assumes: Wishbone byte addresses, 32-bit words, low bits used.
// Notes:   Definitions only; included by the zone controller modules.
`ifndef BTZC_DEFINES_VH
`define BTZC_DEFINES_VH

// Register byte offsets.
`define BTZC_CTRL_OFS      8'h00
`define BTZC_THR_OFS       8'h04
`define BTZC_CHGV_OFS      8'h08
`define BTZC_CHGC_OFS      8'h0C
`define BTZC_MODV_OFS      8'h10
`define BTZC_MODC_OFS      8'h14
`define BTZC_SYSV_OFS      8'h18
`define BTZC_STAT_OFS      8'h1C
`define BTZC_IRQ_OFS       8'h20
`define BTZC_MASK_OFS      8'h24
`define BTZC_OUT_OFS       8'h28

// Control register fields.
`define BTZC_CTRL_EN_BIT   0
`define BTZC_CTRL_MUX_LSB  4

// Threshold register: hot, warm, cool, cold at 2-bit steps.
`define BTZC_THR_HOT_LSB   0
`define BTZC_THR_WARM_LSB  2
`define BTZC_THR_COOL_LSB  4
`define BTZC_THR_COLD_LSB  6

// Interrupt bit positions.
`define BTZC_IRQ_TEMP_BIT  0
`define BTZC_IRQ_SYSV_BIT  1

// Reset values.
`define BTZC_THR_RST       8'h00
`define BTZC_CV_RST        6'h00
`define BTZC_SYSV_RST      6'h3F

// Margin of 200 mV in charge-voltage steps of 25 mV.
`define BTZC_MARGIN_MV     200
`define BTZC_STEP_MV       25

// Temperature zone codes.
`define BTZC_ZONE_COLD     3'h0
`define BTZC_ZONE_COOL     3'h1
`define BTZC_ZONE_NORM     3'h2
`define BTZC_ZONE_WARM     3'h3
`define BTZC_ZONE_HOT      3'h4
`define BTZC_ZONE_OFF      3'h5

// Analog multiplexer channels that need the thermistor bias.
`define BTZC_MUX_THM       4'h7
`define BTZC_MUX_BIAS      4'h8

`endif

// ==== btzc_zone_classify.v ====
// Purpose: Classify battery temperature zone from comparator flags.
// Assumes: Flags synchronous to clk_i; each high when past its threshold.
// Notes:   Registered zone output, one cycle latency.
module btzc_zone_classify
(
  // Clock and reset.
  input  wire       clk_i,
  input  wire       rst_i,
  // Comparator flags and enable.
  input  wire       enable_i,
  input  wire       hot_i,
  input  wire       warm_i,
  input  wire       cool_i,
  input  wire       cold_i,
  // Zone result.
  output reg  [2:0] zone_o
);
`include "btzc_defines.vh"

  // Extremes win over warm and cool so a failing comparator chain cannot
  // hide a fault behind a milder zone.
  always @(posedge clk_i)
  begin
    if (rst_i)
      zone_o <= `BTZC_ZONE_OFF;
    else if (!enable_i)
      zone_o <= `BTZC_ZONE_OFF;
    else if (hot_i)
      zone_o <= `BTZC_ZONE_HOT;
    else if (cold_i)
      zone_o <= `BTZC_ZONE_COLD;
    else if (warm_i)
      zone_o <= `BTZC_ZONE_WARM;
    else if (cool_i)
      zone_o <= `BTZC_ZONE_COOL;
    else
      zone_o <= `BTZC_ZONE_NORM;
  end

endmodule // btzc_zone_classify

// ==== btzc_thm_model.sv ====
// Purpose: Thermistor comparator bank that feeds the zone controller.
// Assumes: The bench asks for a zone in the status field coding.
// Notes:   Trip points nest, so a hot battery is also past warm.
`include "btzc_defines.vh"
module btzc_thm_model
(
  // Requested battery zone.
  input  wire [2:0] zone_i,
  // Comparator flags.
  output wire       hot_o,
  output wire       warm_o,
  output wire       cool_o,
  output wire       cold_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Two flags stand together at the extremes to test precedence.
  assign hot_o  = zone_i == `BTZC_ZONE_HOT;
  assign warm_o = hot_o || zone_i == `BTZC_ZONE_WARM;
  assign cold_o = zone_i == `BTZC_ZONE_COLD;
  assign cool_o = cold_o || zone_i == `BTZC_ZONE_COOL;
endmodule // btzc_thm_model

// ==== btzc_checker.sv ====
// Purpose: Port checks of the battery zone controller.
// Assumes: Zone one cycle after the flags, outputs one cycle later.
// Notes:   Enable and mux bits are mirrored from observed bus writes.
`include "btzc_defines.vh"
module btzc_checker
(
  // Clock and reset.
  input wire        clk_i,
  input wire        rst_i,
  // Bus side.
  input wire        cyc_i,
  input wire        stb_i,
  input wire        we_i,
  input wire [7:0]  adr_i,
  input wire [3:0]  sel_i,
  input wire [31:0] dat_i,
  input wire        ack_o,
  // Comparators and charger input.
  input wire        hot_cmp_i,
  input wire        warm_cmp_i,
  input wire        cool_cmp_i,
  input wire        cold_cmp_i,
  input wire        charger_input_valid_i,
  // Responses.
  input wire        thermistor_bias_en_o,
  input wire        modified_state_o,
  input wire        temp_fault_o,
  input wire        charge_pause_o,
  input wire        timer_pause_o,
  input wire        fault_o,
  input wire        irq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  reg        en_q;
  reg  [3:0] mux_q;
  wire       ext = hot_cmp_i || cold_cmp_i;
  wire       calm = !ext && !warm_cmp_i && !cool_cmp_i;
  wire       ctrl_wr = cyc_i && stb_i && we_i && !ack_o && sel_i[0] &&
                       adr_i == `BTZC_CTRL_OFS;
  // Mirror the control bits; the design takes a write on the same edge.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      en_q  <= 1'b0;
      mux_q <= 4'h0;
    end
    else if (ctrl_wr)
    begin
      en_q  <= dat_i[`BTZC_CTRL_EN_BIT];
      mux_q <= dat_i[7:4];
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_one_cycle:
    assert property (ack_o |=> !ack_o) else $error("ack stood too long");
  a_ack_answer:
    assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request left unanswered");
  a_extreme_fault:
    assert property ((en_q && ext) [*3] |-> temp_fault_o && !modified_state_o)
    else $error("extreme zone without fault");
  a_mild_modified:
    assert property ((en_q && !ext && (warm_cmp_i ^ cool_cmp_i)) [*3]
      |-> modified_state_o && !temp_fault_o)
    else $error("mild zone not modified");
  a_normal_plain:
    assert property ((en_q && calm) [*3]
      |-> !modified_state_o && !temp_fault_o)
    else $error("normal zone modified");
  a_off_inert:
    assert property (!en_q [*3]
      |-> !modified_state_o && !temp_fault_o && charge_pause_o == fault_o)
    else $error("response while disabled");
  a_fault_pauses:
    assert property (temp_fault_o |-> charge_pause_o && timer_pause_o)
    else $error("fault without pause");
  a_bias_needed:
    assert property (((en_q && charger_input_valid_i) ||
      mux_q == `BTZC_MUX_THM || mux_q == `BTZC_MUX_BIAS) [*2]
      |-> thermistor_bias_en_o)
    else $error("bias source off");
  c_fault: cover property (temp_fault_o);
  c_modified: cover property (modified_state_o);
  c_irq: cover property (irq_o);
endmodule // btzc_checker
bind btzc_zone_ctrl btzc_checker i_btzc_checker (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
  .ack_o(ack_o), .hot_cmp_i(hot_cmp_i), .warm_cmp_i(warm_cmp_i),
  .cool_cmp_i(cool_cmp_i), .cold_cmp_i(cold_cmp_i),
  .charger_input_valid_i(charger_input_valid_i),
  .thermistor_bias_en_o(thermistor_bias_en_o),
  .modified_state_o(modified_state_o), .temp_fault_o(temp_fault_o),
  .charge_pause_o(charge_pause_o), .timer_pause_o(timer_pause_o),
  .fault_o(fault_o), .irq_o(irq_o));

// ==== btzc_zone_ctrl_test.sv ====
// Purpose: Self-checking bench of the battery zone controller.
// Assumes: Single-cycle Wishbone answer, two-cycle zone response.
// Notes:   Zone walk, masking, mux bias, fault priority, voltage clamp.
`include "btzc_defines.vh"
module btzc_zone_ctrl_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i = 1'b0;
  logic [7:0]  adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0;
  logic [2:0]  temp_q = `BTZC_ZONE_NORM;
  logic        vin_q = 1'b0;
  logic        oflt_q = 1'b0;
  logic [31:0] rdata;
  logic        mild;
  logic        hard;
  int          error_cnt = 0;
  int          samples_checked = 0;
  logic [2:0]  walk [6] = '{`BTZC_ZONE_NORM, `BTZC_ZONE_WARM,
    `BTZC_ZONE_HOT, `BTZC_ZONE_COOL, `BTZC_ZONE_COLD, `BTZC_ZONE_NORM};
  wire  [31:0] dat_o;
  wire  [7:0]  thr;
  wire  [5:0]  act_v;
  wire  [5:0]  act_c;
  wire         ack_o, hot, warm, cool, cold, bias, modf, tflt, pause;
  wire         tpause, fault, irq_o;
  wire  [3:0]  mux;
  // Clock at 100 ns period.
  always #50 clk_i = ~clk_i;
  btzc_thm_model i_btzc_thm_model (.zone_i(temp_q), .hot_o(hot),
    .warm_o(warm), .cool_o(cool), .cold_o(cold));
  btzc_zone_ctrl i_btzc_zone_ctrl (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(4'hF), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .hot_cmp_i(hot), .warm_cmp_i(warm), .cool_cmp_i(cool),
    .cold_cmp_i(cold), .charger_input_valid_i(vin_q),
    .other_fault_i(oflt_q), .threshold_sel_o(thr),
    .thermistor_bias_en_o(bias), .active_voltage_o(act_v),
    .active_current_o(act_c), .modified_state_o(modf),
    .temp_fault_o(tflt), .charge_pause_o(pause), .timer_pause_o(tpause),
    .fault_o(fault), .monitor_mux_sel_o(mux), .irq_o(irq_o));
  // Ends the run; also reached by the watchdog.
  task automatic finish_test();
    $display("TB: %0d bad of %0d checks", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %0t mismatch got %0h exp %0h", $time, got, exp);
    end
  endtask
  // Holds the request until ack is sampled, so no slave is outrun.
  task automatic xfer(input logic [7:0] a, input logic w,
                      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    do
      @(posedge clk_i);
    while (ack_o !== 1'b1 && ++n < 20);
    if (n == 20)
      check(32'h0, 32'h1);
    rdata = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0);
    check(rdata, exp);
  endtask
  // New zone, then enough edges for status and outputs to follow.
  task automatic step(input logic [2:0] z);
    @(posedge clk_i);
    temp_q <= z;
    repeat (3) @(posedge clk_i);
  endtask
  // Watchdog far beyond the some 175 cycles the tests take.
  initial
  begin
    #1000000;
    error_cnt++;
    $display("BAD %0t watchdog expired", $time);
    finish_test();
  end
  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`BTZC_STAT_OFS, 32'(`BTZC_ZONE_OFF));
    rd(`BTZC_SYSV_OFS, 32'h3F);
    rd(8'h3C, 32'h0);
    wr(`BTZC_THR_OFS, 32'hE4);
    rd(`BTZC_THR_OFS, 32'hE4);
    check(32'(thr), 32'hE4);
    $display("TB: reset and thresholds done");
    wr(`BTZC_CHGV_OFS, 32'h20);
    wr(`BTZC_CHGC_OFS, 32'h11);
    wr(`BTZC_MODV_OFS, 32'h18);
    wr(`BTZC_MODC_OFS, 32'h08);
    wr(`BTZC_MASK_OFS, 32'h1);
    vin_q <= 1'b1;
    wr(`BTZC_CTRL_OFS, 32'h1);
    foreach (walk[i])
    begin
      step(walk[i]);
      mild = walk[i] == `BTZC_ZONE_WARM || walk[i] == `BTZC_ZONE_COOL;
      hard = walk[i] == `BTZC_ZONE_HOT || walk[i] == `BTZC_ZONE_COLD;
      rd(`BTZC_STAT_OFS, 32'(walk[i]));
      check(32'(modf), 32'(mild));
      check(32'(tflt), 32'(hard));
      check(32'(pause), 32'(hard));
      check(32'(tpause), 32'(hard));
      check(32'(bias), 32'h1);
      if (!hard)
      begin
        check(32'(act_v), mild ? 32'h18 : 32'h20);
        check(32'(act_c), mild ? 32'h08 : 32'h11);
      end
      check(32'(irq_o), 32'h1);
      rd(`BTZC_IRQ_OFS, 32'h1);
      wr(`BTZC_IRQ_OFS, 32'h1);
      check(32'(irq_o), 32'h0);
    end
    $display("TB: zone walk done");
    wr(`BTZC_MASK_OFS, 32'h0);
    step(`BTZC_ZONE_WARM);
    check(32'(irq_o), 32'h0);
    rd(`BTZC_IRQ_OFS, 32'h1);
    wr(`BTZC_CTRL_OFS, 32'h71);
    step(temp_q);
    check(32'(modf), 32'h1);
    check(32'(mux), 32'h7);
    vin_q <= 1'b0;
    wr(`BTZC_CTRL_OFS, 32'h80);
    step(temp_q);
    rd(`BTZC_STAT_OFS, 32'(`BTZC_ZONE_OFF));
    check(32'(modf), 32'h0);
    check(32'(bias), 32'h1);
    check(32'(mux), 32'h8);
    $display("TB: mask and mux done");
    vin_q <= 1'b1;
    oflt_q <= 1'b1;
    wr(`BTZC_CTRL_OFS, 32'h1);
    step(`BTZC_ZONE_HOT);
    check(32'(tflt), 32'h1);
    check(32'(fault), 32'h0);
    step(`BTZC_ZONE_NORM);
    check(32'(fault), 32'h1);
    oflt_q <= 1'b0;
    wr(`BTZC_IRQ_OFS, 32'h3);
    wr(`BTZC_SYSV_OFS, 32'h10);
    wr(`BTZC_CHGV_OFS, 32'h0C);
    step(temp_q);
    rd(`BTZC_CHGV_OFS, 32'h08);
    check(32'(act_v), 32'h08);
    rd(`BTZC_IRQ_OFS, 32'h2);
    vin_q <= 1'b0;
    step(temp_q);
    check(32'(bias), 32'h0);
    $display("TB: fault and clamp done");
    finish_test();
  end
endmodule // btzc_zone_ctrl_test
